/* File: core/dsq_sequencer.sv */
// Drive operation sequencer: head positioning, head select, MFM write, read separator
`timescale 1ns/1ps
module dsq_sequencer #(
  parameter int unsigned P_READY_CYC = dsq_pkg::START_TO_READY_CYC,
  parameter int unsigned P_SEEK_TO_CYC = dsq_pkg::SEEK_TIMEOUT_CYC,
  parameter int unsigned P_RETRACT_TO_CYC = dsq_pkg::RETRACT_TIMEOUT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_sw_i,
  input wire logic power_ok_i,
  input wire logic supply_ok_i,
  input wire logic pack_seated_i,
  input wire logic spindle_at_speed_i,
  input wire logic addr_plug_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [9:0] cmd_cyl_i,
  input wire logic [4:0] cmd_head_i,
  input wire logic cmd_offset_dir_i,
  input wire logic [9:0] servo_cyl_i,
  input wire logic servo_on_track_i,
  input wire logic heads_retracted_i,
  input wire logic wr_data_i,
  input wire logic wr_bit_stb_i,
  input wire logic rd_flux_i,
  output logic spindle_on_o,
  output logic heads_load_o,
  output logic [9:0] servo_target_o,
  output logic servo_move_o,
  output logic servo_offset_o,
  output logic servo_offset_dir_o,
  output logic heads_retract_o,
  output logic emerg_retract_o,
  output logic ready_o,
  output logic ready_lamp_o,
  output logic seek_incomplete_o,
  output logic [4:0] head_sel_o,
  output logic head_sel_valid_o,
  output logic wr_gate_o,
  output logic wr_clk_pulse_o,
  output logic wr_data_pulse_o,
  output logic rd_gate_o,
  output logic rd_data_o,
  output logic rd_strobe_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dsq_pkg::dsq_state_e st_q, st_d;
  dsq_pkg::dsq_xfer_e xfer_q, xfer_d;
  logic [31:0] rdy_tmr_q, rdy_tmr_d;
  logic [31:0] op_tmr_q, op_tmr_d;
  logic [9:0] tgt_q, tgt_d;
  logic [4:0] head_q, head_d;
  logic plug_q, plug_d;
  logic recal_pend_q, recal_pend_d;
  logic seek_inc_q, seek_inc_d;
  logic move_q, move_d;
  logic offs_q, offs_d;
  logic offs_dir_q, offs_dir_d;
  logic ready_q, ready_d;
  logic spin_q, spin_d;
  logic load_q, load_d;
  logic retr_q, retr_d;
  logic emerg_q, emerg_d;
  logic hsv_q, hsv_d;
  logic wr_gate_q, wr_gate_d;
  logic wr_prev_q, wr_prev_d;
  logic wr_clk_q, wr_clk_d;
  logic wr_dat_q, wr_dat_d;
  logic rd_gate_q, rd_gate_d;
  logic [1:0] cell_q, cell_d;
  logic seen_q, seen_d;
  logic rd_dat_q, rd_dat_d;
  logic rd_stb_q, rd_stb_d;
  logic stop;
  logic pwr_fail;
  logic arrived;
  logic lock_ok;
  logic op_done;
  logic in_clk_win;

  // ---------------------------------------------------------------
  // Conditions
  // ---------------------------------------------------------------
  always_comb begin
    // An unseated pack counts as a stop request
    stop = !start_sw_i || !pack_seated_i;
    pwr_fail = !power_ok_i || !supply_ok_i;
    // Servo has not seen a launch yet while move is high; its lock is stale
    arrived = servo_on_track_i && (servo_cyl_i == tgt_q) && !move_q;
    lock_ok = (st_q == dsq_pkg::ST_READY) && servo_on_track_i;
    op_done = (op_tmr_q == 32'h0);
    in_clk_win = (cell_q < dsq_pkg::CELL_DATA_WIN);
  end

  // ---------------------------------------------------------------
  // Positioning sequence
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    head_d = head_q;
    xfer_d = xfer_q;
    seek_inc_d = seek_inc_q;
    offs_d = offs_q;
    offs_dir_d = offs_dir_q;
    move_d = 1'b0;
    plug_d = addr_plug_i;
    recal_pend_d = recal_pend_q;
    rdy_tmr_d = (rdy_tmr_q != 32'h0) ? rdy_tmr_q - 32'h1 : 32'h0;
    op_tmr_d = op_done ? 32'h0 : op_tmr_q - 32'h1;
    if (addr_plug_i && !plug_q && st_q != dsq_pkg::ST_IDLE) begin
      recal_pend_d = 1'b1;
    end
    unique case (st_q)
      dsq_pkg::ST_IDLE: begin
        recal_pend_d = 1'b0;
        xfer_d = dsq_pkg::XF_IDLE;
        if (!stop && !pwr_fail) begin
          st_d = dsq_pkg::ST_SPINUP;
          rdy_tmr_d = P_READY_CYC;
        end
      end
      dsq_pkg::ST_SPINUP: begin
        if (stop || pwr_fail) begin
          st_d = dsq_pkg::ST_IDLE;
        end else if (spindle_at_speed_i) begin
          st_d = dsq_pkg::ST_LOAD;
          tgt_d = dsq_pkg::CYL_HOME;
          move_d = 1'b1;
          op_tmr_d = P_SEEK_TO_CYC;
        end
      end
      dsq_pkg::ST_RETRACT: begin
        if (heads_retracted_i) begin
          st_d = dsq_pkg::ST_IDLE;
        end else if (op_done || pwr_fail) begin
          st_d = dsq_pkg::ST_EMERG;
        end
      end
      dsq_pkg::ST_EMERG: begin
        // Hold off restart until the operator releases start
        if (heads_retracted_i && !start_sw_i) begin
          st_d = dsq_pkg::ST_IDLE;
        end
      end
      default: begin
        if (pwr_fail) begin
          st_d = dsq_pkg::ST_EMERG;
        end else if (stop) begin
          st_d = dsq_pkg::ST_RETRACT;
          op_tmr_d = P_RETRACT_TO_CYC;
        end else begin
          unique case (st_q)
            dsq_pkg::ST_LOAD: begin
              if (arrived && rdy_tmr_q == 32'h0) begin
                st_d = dsq_pkg::ST_READY;
              end else if (op_done && !arrived) begin
                st_d = dsq_pkg::ST_RECAL;
                move_d = 1'b1;
                op_tmr_d = P_SEEK_TO_CYC;
              end
            end
            dsq_pkg::ST_SEEK: begin
              if (arrived) begin
                st_d = dsq_pkg::ST_READY;
              end else if (op_done) begin
                seek_inc_d = 1'b1;
                st_d = dsq_pkg::ST_RECAL;
                tgt_d = dsq_pkg::CYL_HOME;
                move_d = 1'b1;
                op_tmr_d = P_SEEK_TO_CYC;
              end
            end
            dsq_pkg::ST_RECAL: begin
              if (arrived) begin
                st_d = dsq_pkg::ST_READY;
              end else if (op_done) begin
                st_d = dsq_pkg::ST_EMERG;
              end
            end
            dsq_pkg::ST_OFFSET: begin
              if (servo_on_track_i && !move_q) begin
                st_d = dsq_pkg::ST_READY;
              end else if (op_done) begin
                st_d = dsq_pkg::ST_RECAL;
                tgt_d = dsq_pkg::CYL_HOME;
                offs_d = 1'b0;
                move_d = 1'b1;
                op_tmr_d = P_SEEK_TO_CYC;
              end
            end
            dsq_pkg::ST_READY: begin
              if (recal_pend_q) begin
                recal_pend_d = 1'b0;
                st_d = dsq_pkg::ST_RECAL;
                tgt_d = dsq_pkg::CYL_HOME;
                offs_d = 1'b0;
                xfer_d = dsq_pkg::XF_IDLE;
                move_d = 1'b1;
                op_tmr_d = P_SEEK_TO_CYC;
              end else if (cmd_valid_i) begin
                if (cmd_op_i == dsq_pkg::OP_SEEK) begin
                  st_d = dsq_pkg::ST_SEEK;
                  tgt_d = cmd_cyl_i;
                  seek_inc_d = 1'b0;
                  offs_d = 1'b0;
                  xfer_d = dsq_pkg::XF_IDLE;
                  move_d = 1'b1;
                  op_tmr_d = P_SEEK_TO_CYC;
                end else if (cmd_op_i == dsq_pkg::OP_RECAL) begin
                  st_d = dsq_pkg::ST_RECAL;
                  tgt_d = dsq_pkg::CYL_HOME;
                  offs_d = 1'b0;
                  xfer_d = dsq_pkg::XF_IDLE;
                  move_d = 1'b1;
                  op_tmr_d = P_SEEK_TO_CYC;
                end else if (cmd_op_i == dsq_pkg::OP_OFFSET) begin
                  st_d = dsq_pkg::ST_OFFSET;
                  offs_d = 1'b1;
                  offs_dir_d = cmd_offset_dir_i;
                  xfer_d = dsq_pkg::XF_IDLE;
                  move_d = 1'b1;
                  op_tmr_d = P_SEEK_TO_CYC;
                end else if ((cmd_op_i == dsq_pkg::OP_READ ||
                              cmd_op_i == dsq_pkg::OP_WRITE) &&
                             cmd_head_i < dsq_pkg::NUM_DATA_HEADS) begin
                  head_d = cmd_head_i;
                  xfer_d = (cmd_op_i == dsq_pkg::OP_READ) ?
                           dsq_pkg::XF_READ : dsq_pkg::XF_WRITE;
                end else if (cmd_op_i == dsq_pkg::OP_XFER_END) begin
                  xfer_d = dsq_pkg::XF_IDLE;
                end
              end
            end
            default: begin
              st_d = dsq_pkg::ST_EMERG;
            end
          endcase
        end
      end
    endcase
    // Transfer mode drops to idle whenever the next state is not ready
    if (st_d != dsq_pkg::ST_READY) begin
      xfer_d = dsq_pkg::XF_IDLE;
    end
    if (rst_i) begin
      st_d = dsq_pkg::ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Status and drive outputs
  // ---------------------------------------------------------------
  always_comb begin
    ready_d = (st_d == dsq_pkg::ST_READY);
    spin_d = (st_d == dsq_pkg::ST_SPINUP) || (st_d == dsq_pkg::ST_LOAD) ||
             (st_d == dsq_pkg::ST_READY) || (st_d == dsq_pkg::ST_SEEK) ||
             (st_d == dsq_pkg::ST_RECAL) || (st_d == dsq_pkg::ST_OFFSET) ||
             (st_d == dsq_pkg::ST_RETRACT);
    load_d = spin_d && (st_d != dsq_pkg::ST_SPINUP) && (st_d != dsq_pkg::ST_RETRACT);
    retr_d = (st_d == dsq_pkg::ST_RETRACT);
    emerg_d = (st_d == dsq_pkg::ST_EMERG);
    hsv_d = lock_ok && (xfer_q != dsq_pkg::XF_IDLE);
    wr_gate_d = lock_ok && (xfer_q == dsq_pkg::XF_WRITE);
    rd_gate_d = lock_ok && (xfer_q == dsq_pkg::XF_READ);
  end

  // ---------------------------------------------------------------
  // MFM write encoder
  // ---------------------------------------------------------------
  always_comb begin
    wr_clk_d = 1'b0;
    wr_dat_d = 1'b0;
    wr_prev_d = wr_gate_q ? wr_prev_q : 1'b0;
    if (wr_gate_q && wr_bit_stb_i) begin
      // Clock pulse only between two zero cells
      wr_dat_d = wr_data_i;
      wr_clk_d = !wr_data_i && !wr_prev_q;
      wr_prev_d = wr_data_i;
    end
  end

  // ---------------------------------------------------------------
  // Read data separator
  // ---------------------------------------------------------------
  always_comb begin
    cell_d = 2'h0;
    seen_d = 1'b0;
    rd_dat_d = 1'b0;
    rd_stb_d = 1'b0;
    if (rd_gate_q) begin
      cell_d = cell_q + 2'h1;
      seen_d = seen_q;
      if (rd_flux_i && in_clk_win) begin
        // Clock pulses pull the window; a crude lock, no frequency track
        cell_d = dsq_pkg::CELL_RESYNC;
      end else if (rd_flux_i) begin
        seen_d = 1'b1;
      end
      if (cell_q == dsq_pkg::CELL_LAST) begin
        rd_stb_d = 1'b1;
        rd_dat_d = seen_q || rd_flux_i;
        seen_d = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= dsq_pkg::ST_IDLE;
      xfer_q <= dsq_pkg::XF_IDLE;
      rdy_tmr_q <= 32'h0;
      op_tmr_q <= 32'h0;
      tgt_q <= dsq_pkg::CYL_HOME;
      head_q <= 5'h00;
      plug_q <= 1'b0;
      recal_pend_q <= 1'b0;
      seek_inc_q <= 1'b0;
      move_q <= 1'b0;
      offs_q <= 1'b0;
      offs_dir_q <= 1'b0;
      ready_q <= 1'b0;
      spin_q <= 1'b0;
      load_q <= 1'b0;
      retr_q <= 1'b0;
      emerg_q <= 1'b0;
      hsv_q <= 1'b0;
      wr_gate_q <= 1'b0;
      wr_prev_q <= 1'b0;
      wr_clk_q <= 1'b0;
      wr_dat_q <= 1'b0;
      rd_gate_q <= 1'b0;
      cell_q <= 2'h0;
      seen_q <= 1'b0;
      rd_dat_q <= 1'b0;
      rd_stb_q <= 1'b0;
    end else begin
      st_q <= st_d;
      xfer_q <= xfer_d;
      rdy_tmr_q <= rdy_tmr_d;
      op_tmr_q <= op_tmr_d;
      tgt_q <= tgt_d;
      head_q <= head_d;
      plug_q <= plug_d;
      recal_pend_q <= recal_pend_d;
      seek_inc_q <= seek_inc_d;
      move_q <= move_d;
      offs_q <= offs_d;
      offs_dir_q <= offs_dir_d;
      ready_q <= ready_d;
      spin_q <= spin_d;
      load_q <= load_d;
      retr_q <= retr_d;
      emerg_q <= emerg_d;
      hsv_q <= hsv_d;
      wr_gate_q <= wr_gate_d;
      wr_prev_q <= wr_prev_d;
      wr_clk_q <= wr_clk_d;
      wr_dat_q <= wr_dat_d;
      rd_gate_q <= rd_gate_d;
      cell_q <= cell_d;
      seen_q <= seen_d;
      rd_dat_q <= rd_dat_d;
      rd_stb_q <= rd_stb_d;
    end
  end

  assign spindle_on_o = spin_q;
  assign heads_load_o = load_q;
  assign servo_target_o = tgt_q;
  assign servo_move_o = move_q;
  assign servo_offset_o = offs_q;
  assign servo_offset_dir_o = offs_dir_q;
  assign heads_retract_o = retr_q;
  assign emerg_retract_o = emerg_q;
  assign ready_o = ready_q;
  assign ready_lamp_o = ready_q;
  assign seek_incomplete_o = seek_inc_q;
  assign head_sel_o = head_q;
  assign head_sel_valid_o = hsv_q;
  assign wr_gate_o = wr_gate_q;
  assign wr_clk_pulse_o = wr_clk_q;
  assign wr_data_pulse_o = wr_dat_q;
  assign rd_gate_o = rd_gate_q;
  assign rd_data_o = rd_dat_q;
  assign rd_strobe_o = rd_stb_q;
endmodule

/* File: core/dsq_pkg.sv */
// Constants, types and timing for the disc drive operation sequencer
// Function
// - Start switch spins pack, head load to 000
// - Ready and lamp about 20 s after start
// - When ready, accept seek, head, read, write
// - Recalibrate returns heads to cylinder 000
// - Recalibrate by command, address plug, seek incomplete
// - Seek by command moves heads to cylinder
// - Failed seek reports incomplete, then recalibrates
// - Offset seek moves heads off track centreline
// - Stop retracts heads so pack is removable
// - Emergency retract on retract or power failure
// - Select one of 19 data heads only
// - Head select and transfer only when locked
// - Write stream is MFM encoded into pulses
// - Separator splits clock, strobes each read bit
// - Unseated pack blocks all drive operation
// - Ready stays low from seek strobe until on cylinder
package dsq_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned START_TO_READY_MS = 20000;
  localparam int unsigned START_TO_READY_CYC = START_TO_READY_MS * CYC_PER_MS;
  // Generous bounds; a healthy seek ends far sooner
  localparam int unsigned SEEK_TIMEOUT_MS = 100;
  localparam int unsigned SEEK_TIMEOUT_CYC = SEEK_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned RETRACT_TIMEOUT_MS = 2000;
  localparam int unsigned RETRACT_TIMEOUT_CYC = RETRACT_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned TMR_W = 32;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned CYL_W = 10;
  localparam logic [9:0] CYL_HOME = 10'h000;
  localparam int unsigned HEAD_W = 5;
  localparam logic [4:0] NUM_DATA_HEADS = 5'h13;
  // ---------------------------------------------------------------
  // Read bit cell of four clocks: two clock, two data window
  // ---------------------------------------------------------------
  localparam logic [1:0] CELL_DATA_WIN = 2'h2;
  localparam logic [1:0] CELL_LAST = 2'h3;
  localparam logic [1:0] CELL_RESYNC = 2'h2;
  // ---------------------------------------------------------------
  // Commands, transfer modes, states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SEEK = 3'h1,
    OP_RECAL = 3'h2,
    OP_OFFSET = 3'h3,
    OP_READ = 3'h4,
    OP_WRITE = 3'h5,
    OP_XFER_END = 3'h6
  } dsq_op_e;
  typedef enum logic [1:0] {
    XF_IDLE = 2'h0,
    XF_READ = 2'h1,
    XF_WRITE = 2'h2
  } dsq_xfer_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SPINUP = 4'h1,
    ST_LOAD = 4'h3,
    ST_READY = 4'h2,
    ST_SEEK = 4'h6,
    ST_RECAL = 4'h7,
    ST_OFFSET = 4'h5,
    ST_RETRACT = 4'h4,
    ST_EMERG = 4'hc
  } dsq_state_e;
endpackage

/* File: verif/dsq_plant_model.sv */
// Spindle, servo and carriage plant model facing the sequencer
`timescale 1ns/1ps
module dsq_plant_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic spindle_on_i,
  input wire logic heads_load_i,
  input wire logic move_i,
  input wire logic [9:0] target_i,
  input wire logic retract_i,
  input wire logic emerg_i,
  input wire logic stall_seek_i,
  input wire logic stall_ret_i,
  output logic at_speed_o,
  output logic [9:0] cyl_o,
  output logic on_track_o,
  output logic retracted_o
);
  // ---------------------------------------------------------------
  // Mechanics
  // ---------------------------------------------------------------
  logic [3:0] spin_q;
  logic [2:0] mv_q;
  logic [2:0] rt_q;
  logic [9:0] pos_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      spin_q <= 4'h0;
      mv_q <= 3'h6;
      rt_q <= 3'h0;
      pos_q <= 10'h000;
      retracted_o <= 1'b1;
    end else begin
      spin_q <= !spindle_on_i ? 4'h0 : (spin_q == 4'h8 ? spin_q : spin_q + 4'h1);
      if (move_i) begin
        mv_q <= 3'h0;
        pos_q <= target_i;
      end else if (mv_q != 3'h6) begin
        mv_q <= mv_q + 3'h1;
      end
      // Emergency withdrawal works even when the normal path is jammed
      if ((retract_i && !stall_ret_i) || emerg_i) begin
        rt_q <= (rt_q == 3'h4) ? rt_q : rt_q + 3'h1;
      end else begin
        rt_q <= 3'h0;
      end
      if (heads_load_i) begin
        retracted_o <= 1'b0;
      end else if (rt_q == 3'h4) begin
        retracted_o <= 1'b1;
      end
    end
  end
  assign at_speed_o = spin_q == 4'h8;
  assign on_track_o = heads_load_i && mv_q == 3'h6 && !stall_seek_i;
  // Off track the cylinder bus shows garbage, never the old value
  assign cyl_o = on_track_o ? pos_q : ~pos_q;
endmodule

/* File: verif/dsq_sequencer_sva.sv */
// Port checker for the drive operation sequencer
`timescale 1ns/1ps
module dsq_sequencer_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_sw_i,
  input wire logic power_ok_i,
  input wire logic supply_ok_i,
  input wire logic pack_seated_i,
  input wire logic addr_plug_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [9:0] cmd_cyl_i,
  input wire logic servo_on_track_i,
  input wire logic wr_data_i,
  input wire logic wr_bit_stb_i,
  input wire logic heads_load_o,
  input wire logic [9:0] servo_target_o,
  input wire logic servo_move_o,
  input wire logic emerg_retract_o,
  input wire logic ready_o,
  input wire logic ready_lamp_o,
  input wire logic [4:0] head_sel_o,
  input wire logic head_sel_valid_o,
  input wire logic wr_gate_o,
  input wire logic wr_clk_pulse_o,
  input wire logic wr_data_pulse_o,
  input wire logic rd_strobe_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic cmd_ok;
  assign cmd_ok = ready_o && cmd_valid_i && start_sw_i && power_ok_i && supply_ok_i
    && pack_seated_i && !addr_plug_i;
  a_move_drops_ready: assert property (servo_move_o |-> !ready_o)
    else $error("ready high at move launch");
  a_ready_after_lock: assert property ($rose(ready_o) |-> $past(servo_on_track_i))
    else $error("ready rose without lock");
  a_seek_sets_target: assert property (cmd_ok && cmd_op_i == 3'h1 && !$past(addr_plug_i)
    |=> servo_move_o && !ready_o && servo_target_o == $past(cmd_cyl_i))
    else $error("seek not launched");
  a_recal_goes_home: assert property (cmd_ok && cmd_op_i == 3'h2 && !$past(addr_plug_i)
    |=> servo_move_o && servo_target_o == 10'h000)
    else $error("recal not launched home");
  a_head_in_range: assert property (head_sel_valid_o |-> head_sel_o < 5'h13)
    else $error("head out of range");
  a_sel_after_lock: assert property ($rose(head_sel_valid_o) |-> $past(servo_on_track_i))
    else $error("head selected off track");
  a_wr_encode_bit: assert property (wr_gate_o && wr_bit_stb_i |=> wr_data_pulse_o == $past(wr_data_i)
    && !(wr_clk_pulse_o && wr_data_pulse_o))
    else $error("write pulse wrong");
  a_wr_pulse_idle: assert property (!$past(wr_bit_stb_i) |-> !wr_data_pulse_o && !wr_clk_pulse_o)
    else $error("write pulse without bit");
  a_rd_cell_gap: assert property (rd_strobe_o |=> !rd_strobe_o [*2])
    else $error("read strobes too close");
  a_lamp_follows: assert property (ready_lamp_o == ready_o)
    else $error("lamp differs from ready");
  a_unseated_stops: assert property (ready_o && !pack_seated_i |-> ##[1:2] !ready_o)
    else $error("ready kept with pack unseated");
  a_power_emerg: assert property (heads_load_o && !power_ok_i |-> ##[1:2] emerg_retract_o)
    else $error("no emergency retract");
  c_seek: cover property (cmd_ok && cmd_op_i == 3'h1);
  c_read_bit: cover property (rd_strobe_o);
  c_emerg: cover property (emerg_retract_o);
endmodule
bind dsq_sequencer dsq_sequencer_sva u_sva (.*);

/* File: verif/testbench.sv */
// Self-checking bench for the drive operation sequencer
`timescale 1ns/1ps
module testbench;
  localparam int unsigned RDY = 50;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_sw_i, power_ok_i, supply_ok_i, pack_seated_i, addr_plug_i, cmd_valid_i;
  logic cmd_offset_dir_i, wr_data_i, wr_bit_stb_i, rd_flux_i, stall_seek, stall_ret;
  logic [2:0] cmd_op_i;
  logic [9:0] cmd_cyl_i, servo_cyl_i, servo_target_o;
  logic [4:0] cmd_head_i, head_sel_o, h;
  logic spindle_at_speed_i, servo_on_track_i, heads_retracted_i, spindle_on_o, heads_load_o;
  logic servo_move_o, servo_offset_o, servo_offset_dir_o, heads_retract_o, emerg_retract_o;
  logic ready_o, ready_lamp_o, seek_incomplete_o, head_sel_valid_o, wr_gate_o;
  logic wr_clk_pulse_o, wr_data_pulse_o, rd_gate_o, rd_data_o, rd_strobe_o, prev;
  logic [31:0] seed = 32'hdcc1;
  logic [31:0] bits;
  int fails = 0;
  int n_checks = 0;
  time t0;
  always #20 ref_clk_i = ~ref_clk_i;
  dsq_sequencer #(.P_READY_CYC(RDY), .P_SEEK_TO_CYC(40), .P_RETRACT_TO_CYC(60)) dut (.*);
  dsq_plant_model plant (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .spindle_on_i(spindle_on_o),
    .heads_load_i(heads_load_o), .move_i(servo_move_o), .target_i(servo_target_o),
    .retract_i(heads_retract_o), .emerg_i(emerg_retract_o), .stall_seek_i(stall_seek),
    .stall_ret_i(stall_ret), .at_speed_o(spindle_at_speed_i), .cyl_o(servo_cyl_i),
    .on_track_o(servo_on_track_i), .retracted_o(heads_retracted_i));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic mfm_clk(input logic b, input logic p);
    return !b && !p;
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return ready_o;
      1: return rd_gate_o;
      2: return wr_gate_o;
      3: return seek_incomplete_o;
      4: return emerg_retract_o;
      default: return !emerg_retract_o && !spindle_on_o;
    endcase
  endfunction
  task automatic test_done();
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Bounded waits only; a hang ends the run as a mismatch
  task automatic wait_sig(input int w, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (sig(w) === 1'b1) break;
      cyc(1);
    end
    if (i == lim) begin
      fails++;
      test_done();
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [9:0] c, input logic [4:0] hd);
    cmd_op_i = op;
    cmd_cyl_i = c;
    cmd_head_i = hd;
    cmd_valid_i = 1'b1;
    cyc(1);
    cmd_valid_i = 1'b0;
  endtask
  task automatic seek(input logic [9:0] c);
    cmd(3'h1, c, 5'h00);
    chk({servo_move_o, ready_o, servo_target_o}, {2'b10, c});
    wait_sig(0, 40);
    chk(servo_cyl_i, c);
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    {start_sw_i, power_ok_i, supply_ok_i, pack_seated_i, addr_plug_i, cmd_valid_i} = 6'h00;
    {cmd_offset_dir_i, wr_data_i, wr_bit_stb_i, rd_flux_i, stall_seek, stall_ret} = 6'h00;
    {cmd_op_i, cmd_cyl_i, cmd_head_i} = 18'h00000;
    cyc(3);
    rst_i = 1'b0;
    chk({spindle_on_o, ready_o, servo_target_o}, 32'h0);
    {power_ok_i, supply_ok_i, pack_seated_i, start_sw_i} = 4'hf;
    t0 = $time;
    wait_sig(0, 300);
    chk(($time - t0) >= RDY * 40, 1);
    chk({ready_lamp_o, heads_load_o, spindle_on_o, servo_target_o}, {3'h7, 10'h000});
    seek(10'h000);
    seek(10'h32e);
    repeat (5) seek(10'(nxt() % 815));
    cmd(3'h1, 10'h010, 5'h00);
    cyc(1);
    cmd(3'h1, 10'h020, 5'h00);
    chk(servo_target_o, 10'h010);
    wait_sig(0, 40);
    cmd(3'h2, 10'h155, 5'h00);
    chk({servo_move_o, servo_target_o}, {1'b1, 10'h000});
    wait_sig(0, 40);
    cmd_offset_dir_i = 1'b1;
    cmd(3'h3, 10'h000, 5'h00);
    wait_sig(0, 40);
    chk({servo_offset_o, servo_offset_dir_o}, 2'h3);
    seek(10'h005);
    chk(servo_offset_o, 1'b0);
    stall_seek = 1'b1;
    cmd(3'h1, 10'h055, 5'h00);
    wait_sig(3, 60);
    cyc(2);
    chk({seek_incomplete_o, servo_target_o}, {1'b1, 10'h000});
    stall_seek = 1'b0;
    wait_sig(0, 60);
    chk(servo_cyl_i, 10'h000);
    seek(10'h007);
    chk(seek_incomplete_o, 1'b0);
    addr_plug_i = 1'b1;
    cyc(2);
    addr_plug_i = 1'b0;
    cyc(2);
    chk({ready_o, servo_target_o}, {1'b0, 10'h000});
    wait_sig(0, 40);
    cmd(3'h4, 10'h000, 5'h13);
    cyc(3);
    chk(head_sel_valid_o, 1'b0);
    h = 5'(nxt() % 19);
    cmd(3'h4, 10'h000, h);
    wait_sig(1, 10);
    chk({head_sel_valid_o, head_sel_o}, {1'b1, h});
    bits = nxt();
    for (int i = 0; i < 9; i++) begin
      for (int k = 0; k < 4; k++) begin
        if (k == 0 && i > 0) chk({rd_strobe_o, rd_data_o}, {1'b1, bits[i-1]});
        rd_flux_i = (k == 2 && i < 8) ? bits[i] : 1'b0;
        cyc(1);
      end
    end
    cmd(3'h5, 10'h000, 5'h12);
    wait_sig(2, 10);
    prev = 1'b0;
    bits = nxt();
    for (int i = 0; i < 12; i++) begin
      wr_bit_stb_i = 1'b1;
      wr_data_i = bits[i];
      cyc(1);
      chk({wr_data_pulse_o, wr_clk_pulse_o}, {bits[i], mfm_clk(bits[i], prev)});
      prev = bits[i];
    end
    wr_bit_stb_i = 1'b0;
    cmd(3'h6, 10'h000, 5'h00);
    cyc(2);
    chk({wr_gate_o, head_sel_valid_o}, 2'h0);
    pack_seated_i = 1'b0;
    cyc(2);
    chk({ready_o, heads_retract_o}, 2'h1);
    wait_sig(5, 40);
    cyc(3);
    chk({heads_retracted_i, spindle_on_o}, 2'h2);
    pack_seated_i = 1'b1;
    wait_sig(0, 300);
    stall_ret = 1'b1;
    start_sw_i = 1'b0;
    wait_sig(4, 100);
    stall_ret = 1'b0;
    wait_sig(5, 40);
    chk(heads_retracted_i, 1'b1);
    start_sw_i = 1'b1;
    wait_sig(0, 300);
    power_ok_i = 1'b0;
    cyc(2);
    chk(emerg_retract_o, 1'b1);
    start_sw_i = 1'b0;
    power_ok_i = 1'b1;
    wait_sig(5, 40);
    test_done();
  end
endmodule
